// >>> common/rlr_defs.svh
// constants for the routed-frame and oam tag rewriter slice
// assumes plain register port with word-indexed addresses
`ifndef RLR_DEFS_SVH
`define RLR_DEFS_SVH
`define RLR_ADDR_W          8
`define RLR_OFS_LOW_CFG     8'h00
`define RLR_OFS_HIGH_CFG    8'h01
`define RLR_OFS_PORT_BASE   8'h08
`define RLR_OFS_STATUS      8'h10
`define RLR_OFS_LEG_BASE    8'h20
`define RLR_LEGS            32
`define RLR_PORTS           8
`define RLR_TPIDS           4
`define RLR_LOW_RST         24'h000000
`define RLR_HIGH_RST        24'h000000
`define RLR_KIND_RST        2'h0
`define RLR_KIND_LSB        24
`define RLR_STACK_BIT       12
`define RLR_TPID_LSB        0
`define RLR_PCP_LSB         4
`define RLR_DEI_BIT         7
`define RLR_MODE_UC         2'h1
`define RLR_MODE_MC         2'h2
`endif

// >>> common/rlr_pkg.sv
// types for the routed-frame and oam tag rewriter slice
// assumes rlr_defs.svh constants are fixed
package rlr_pkg;
	typedef enum logic [1:0] {
		RLR_IDLE = 2'b00,
		RLR_WAIT = 2'b01,
		RLR_EMIT = 2'b10
	} rlr_state_e;

	// internal header fields the slice reads and writes
	typedef struct packed {
		logic [1:0]  fwd_dest_kind;
		logic        analyzer_routed_forward;
		logic [4:0]  egress_leg_index;
		logic [7:0]  mapped_vlan_index;
		logic [11:0] vid;
		logic [47:0] smac;
		logic        prior_tag_flag;
		logic [9:0]  service_index;
		logic        is_oam;
		logic        pushes_tags;
		logic        outer_tagged;
		logic [1:0]  outer_tpid_sel;
		logic [2:0]  outer_pcp;
		logic        outer_dei;
		logic [2:0]  port;
	} rlr_hdr_s;

	typedef struct packed {
		logic [127:0] pdu;
		logic [2:0]   pcp;
		logic         dei;
	} rlr_oam_req_s;

	typedef struct packed {
		logic [127:0] pdu;
		logic         set_service;
		logic [9:0]   service_index;
	} rlr_oam_rsp_s;

	typedef struct packed {
		rlr_state_e   state;
		rlr_hdr_s     hdr;
		logic [127:0] pdu;
		logic [2:0]   pcp;
		logic         dei;
		logic [15:0]  oam_tx_count;
		logic [31:0]  rd_data;
	} rlr_state_s;
endpackage

// >>> rtl/rlr_rewriter.sv
// routed-frame source address, egress vid and oam tag selection slice
// assumes one frame header at a time from the analyzer, handshake on valid/ready,
// and an oam processor that always answers a request
`timescale 1ns/1ps
`include "rlr_defs.svh"

module rlr_rewriter (
	// clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      reset_n,
	// register port
	input  wire logic [`RLR_ADDR_W-1:0]    reg_addr,
	input  wire logic [31:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [31:0]               reg_rdata,
	// frame header from the analyzer
	input  wire logic                      in_valid,
	output logic                           in_ready,
	input  rlr_pkg::rlr_hdr_s              in_hdr,
	input  wire logic [127:0]              in_pdu,
	// rewritten frame header
	output logic                           out_valid,
	input  wire logic                      out_ready,
	output rlr_pkg::rlr_hdr_s              out_hdr,
	output logic      [127:0]              out_pdu,
	// oam processor
	output logic                           oam_req_valid,
	output rlr_pkg::rlr_oam_req_s          oam_req,
	input  wire logic                      oam_rsp_valid,
	input  rlr_pkg::rlr_oam_rsp_s          oam_rsp
);

	// ------------------------------------------------------------
	// configuration
	// ------------------------------------------------------------
	logic [23:0] leg_addr_low_half_reg;
	logic [23:0] leg_addr_high_half_reg;
	logic [1:0]  leg_addr_kind_select_reg;
	logic [11:0] leg_egress_vlan_id_reg  [`RLR_LEGS];
	logic        leg_stack_tagged_flag_reg [`RLR_LEGS];
	logic [`RLR_TPIDS-1:0] oam_tpid_ignore_mask_reg [`RLR_PORTS];
	logic [2:0]  oam_fallback_priority_reg [`RLR_PORTS];
	logic        oam_fallback_drop_bit_reg [`RLR_PORTS];

	rlr_pkg::rlr_state_s st_reg;
	rlr_pkg::rlr_state_s st_next;

	function automatic logic is_leg(input logic [`RLR_ADDR_W-1:0] a);
		return a >= `RLR_OFS_LEG_BASE && a < (`RLR_OFS_LEG_BASE + 8'(`RLR_LEGS));
	endfunction

	function automatic logic is_port(input logic [`RLR_ADDR_W-1:0] a);
		return a >= `RLR_OFS_PORT_BASE && a < (`RLR_OFS_PORT_BASE + 8'(`RLR_PORTS));
	endfunction

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			leg_addr_low_half_reg    <= `RLR_LOW_RST;
			leg_addr_high_half_reg   <= `RLR_HIGH_RST;
			leg_addr_kind_select_reg <= `RLR_KIND_RST;
			for (int i = 0; i < `RLR_LEGS; i++) begin
				leg_egress_vlan_id_reg[i]    <= 12'h000;
				leg_stack_tagged_flag_reg[i] <= 1'b0;
			end
			for (int i = 0; i < `RLR_PORTS; i++) begin
				oam_tpid_ignore_mask_reg[i]  <= '0;
				oam_fallback_priority_reg[i] <= 3'h0;
				oam_fallback_drop_bit_reg[i] <= 1'b0;
			end
		end else if (reg_wr) begin
			if (reg_addr == `RLR_OFS_LOW_CFG)
				leg_addr_low_half_reg <= reg_wdata[23:0];
			if (reg_addr == `RLR_OFS_HIGH_CFG) begin
				leg_addr_high_half_reg   <= reg_wdata[23:0];
				leg_addr_kind_select_reg <= reg_wdata[`RLR_KIND_LSB +: 2];
			end
			if (is_leg(reg_addr)) begin
				leg_egress_vlan_id_reg[5'(reg_addr - `RLR_OFS_LEG_BASE)] <= reg_wdata[11:0];
				leg_stack_tagged_flag_reg[5'(reg_addr - `RLR_OFS_LEG_BASE)] <=
					reg_wdata[`RLR_STACK_BIT];
			end
			if (is_port(reg_addr)) begin
				oam_tpid_ignore_mask_reg[3'(reg_addr - `RLR_OFS_PORT_BASE)] <=
					reg_wdata[`RLR_TPID_LSB +: `RLR_TPIDS];
				oam_fallback_priority_reg[3'(reg_addr - `RLR_OFS_PORT_BASE)] <=
					reg_wdata[`RLR_PCP_LSB +: 3];
				oam_fallback_drop_bit_reg[3'(reg_addr - `RLR_OFS_PORT_BASE)] <=
					reg_wdata[`RLR_DEI_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// per-frame computation
	// ------------------------------------------------------------
	logic        routed;
	logic [23:0] low_sum;
	logic        untagged_view;
	logic [4:0]  leg_idx;
	logic [2:0]  prt;

	always_comb begin
		leg_idx = in_hdr.egress_leg_index;
		prt     = in_hdr.port;
		// analyzer-forwarded frames bypass the leg settings entirely
		routed  = (in_hdr.fwd_dest_kind == `RLR_MODE_UC ||
			in_hdr.fwd_dest_kind == `RLR_MODE_MC) &&
			!in_hdr.analyzer_routed_forward;
		case (leg_addr_kind_select_reg)
			2'h0:    low_sum = leg_addr_low_half_reg + {16'h0000, in_hdr.mapped_vlan_index};
			2'h1:    low_sum = leg_addr_low_half_reg + {12'h000, in_hdr.vid};
			default: low_sum = leg_addr_low_half_reg;
		endcase
		// mask applies only when the rewriter adds no tags of its own
		untagged_view = !in_hdr.outer_tagged ||
			(!in_hdr.pushes_tags &&
			oam_tpid_ignore_mask_reg[prt][in_hdr.outer_tpid_sel]);
	end

	always_comb begin
		st_next = st_reg;
		st_next.rd_data = 32'h00000000;
		if (reg_rd) begin
			if (reg_addr == `RLR_OFS_LOW_CFG)
				st_next.rd_data = {8'h00, leg_addr_low_half_reg};
			else if (reg_addr == `RLR_OFS_HIGH_CFG)
				st_next.rd_data = {6'h00, leg_addr_kind_select_reg, leg_addr_high_half_reg};
			else if (reg_addr == `RLR_OFS_STATUS)
				st_next.rd_data = {14'h0000, st_reg.state, st_reg.oam_tx_count};
			else if (is_leg(reg_addr))
				st_next.rd_data = {19'h00000,
					leg_stack_tagged_flag_reg[5'(reg_addr - `RLR_OFS_LEG_BASE)],
					leg_egress_vlan_id_reg[5'(reg_addr - `RLR_OFS_LEG_BASE)]};
			else if (is_port(reg_addr))
				st_next.rd_data = {24'h000000,
					oam_fallback_drop_bit_reg[3'(reg_addr - `RLR_OFS_PORT_BASE)],
					oam_fallback_priority_reg[3'(reg_addr - `RLR_OFS_PORT_BASE)],
					oam_tpid_ignore_mask_reg[3'(reg_addr - `RLR_OFS_PORT_BASE)]};
		end
		case (st_reg.state)
			rlr_pkg::RLR_IDLE: begin
				if (in_valid) begin
					st_next.hdr = in_hdr;
					st_next.pdu = in_pdu;
					if (routed) begin
						st_next.hdr.smac = {leg_addr_high_half_reg, low_sum};
						st_next.hdr.vid  = leg_egress_vlan_id_reg[leg_idx];
						st_next.hdr.prior_tag_flag = leg_stack_tagged_flag_reg[leg_idx];
					end
					st_next.pcp = untagged_view ? oam_fallback_priority_reg[prt] :
						in_hdr.outer_pcp;
					st_next.dei = untagged_view ? oam_fallback_drop_bit_reg[prt] :
						in_hdr.outer_dei;
					st_next.state = in_hdr.is_oam ? rlr_pkg::RLR_WAIT :
						rlr_pkg::RLR_EMIT;
				end
			end
			rlr_pkg::RLR_WAIT: begin
				if (oam_rsp_valid) begin
					st_next.pdu = oam_rsp.pdu;
					if (oam_rsp.set_service)
						st_next.hdr.service_index = oam_rsp.service_index;
					st_next.oam_tx_count = st_reg.oam_tx_count + 16'h0001;
					st_next.state = rlr_pkg::RLR_EMIT;
				end
			end
			rlr_pkg::RLR_EMIT: begin
				if (out_ready)
					st_next.state = rlr_pkg::RLR_IDLE;
			end
			default: st_next.state = rlr_pkg::RLR_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign in_ready      = st_reg.state == rlr_pkg::RLR_IDLE;
	assign out_valid     = st_reg.state == rlr_pkg::RLR_EMIT;
	assign out_hdr       = st_reg.hdr;
	assign out_pdu       = st_reg.pdu;
	assign reg_rdata     = st_reg.rd_data;
	assign oam_req_valid = st_reg.state == rlr_pkg::RLR_WAIT;
	assign oam_req       = '{pdu: st_reg.pdu, pcp: st_reg.pcp, dei: st_reg.dei};

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_oam_taken;
		in_valid && in_ready && in_hdr.is_oam;
	endsequence

	sequence s_answered;
		oam_req_valid && oam_rsp_valid;
	endsequence

	chk_oam_goes_out: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_oam_taken |=> oam_req_valid)
		else $error("oam frame not sent to processor");

	chk_wait_for_answer: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(oam_req_valid && !oam_rsp_valid) |=> !out_valid)
		else $error("frame emitted before oam answer");

	chk_answer_emits: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_answered |=> out_valid && out_pdu == $past(oam_rsp.pdu))
		else $error("oam rewrite not applied");

	chk_index_applied: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s_answered and oam_rsp.set_service) |=>
		out_hdr.service_index == $past(oam_rsp.service_index))
		else $error("service index not applied");

	chk_count_step: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_answered |=> st_reg.oam_tx_count == $past(st_reg.oam_tx_count) + 16'h0001)
		else $error("oam count not advanced");

	chk_analyzer_keeps: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(in_valid && in_ready && in_hdr.analyzer_routed_forward) |=>
		st_reg.hdr.smac == $past(in_hdr.smac) && st_reg.hdr.vid == $past(in_hdr.vid))
		else $error("analyzer-forwarded frame changed");

	chk_routed_vid: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(in_valid && in_ready && routed) |=>
		st_reg.hdr.vid == $past(leg_egress_vlan_id_reg[leg_idx]))
		else $error("routed vid not from leg table");

	chk_routed_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(in_valid && in_ready && routed) |=>
		st_reg.hdr.smac[47:24] == $past(leg_addr_high_half_reg))
		else $error("routed high half wrong");

	chk_fallback_pcp: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(in_valid && in_ready && !in_hdr.outer_tagged) |=>
		st_reg.pcp == $past(oam_fallback_priority_reg[prt]))
		else $error("fallback priority not used");

	chk_in_order: assert property (@(posedge ref_clk) disable iff (!reset_n)
		out_valid |-> !in_ready)
		else $error("new frame taken while one pending");

	// table values are taken as they stood at the accepting edge
	sequence s_plain_taken;
		in_valid && in_ready && !in_hdr.is_oam;
	endsequence

	sequence s_routed_taken;
		in_valid && in_ready && routed;
	endsequence

	chk_unrouted_keeps: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(in_valid && in_ready && in_hdr.fwd_dest_kind != `RLR_MODE_UC &&
		in_hdr.fwd_dest_kind != `RLR_MODE_MC) |=> st_reg.hdr == $past(in_hdr))
		else $error("unrouted frame header changed");

	chk_analyzer_whole: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(in_valid && in_ready && in_hdr.analyzer_routed_forward) |=>
		st_reg.hdr == $past(in_hdr))
		else $error("analyzer-forwarded header changed");

	chk_low_plus_index: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(in_valid && in_ready && routed && leg_addr_kind_select_reg == 2'h0) |=>
		st_reg.hdr.smac[23:0] ==
		$past(leg_addr_low_half_reg) + 24'($past(in_hdr.mapped_vlan_index)))
		else $error("low half plus vlan index wrong");

	chk_low_plus_vid: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(in_valid && in_ready && routed && leg_addr_kind_select_reg == 2'h1) |=>
		st_reg.hdr.smac[23:0] ==
		$past(leg_addr_low_half_reg) + 24'($past(in_hdr.vid)))
		else $error("low half plus vid wrong");

	// kinds 2 and 3 give every vlan the same address
	chk_low_shared: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(in_valid && in_ready && routed && leg_addr_kind_select_reg[1]) |=>
		st_reg.hdr.smac[23:0] == $past(leg_addr_low_half_reg))
		else $error("shared low half not used");

	chk_routed_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_routed_taken |=>
		st_reg.hdr.prior_tag_flag == $past(leg_stack_tagged_flag_reg[leg_idx]))
		else $error("routed tagged flag not from leg table");

	chk_fallback_dei: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(in_valid && in_ready && !in_hdr.outer_tagged) |=>
		st_reg.dei == $past(oam_fallback_drop_bit_reg[prt]))
		else $error("fallback drop bit not used");

	// an ignored tpid only counts when the rewriter pushes nothing of its own
	chk_ignored_tpid: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(in_valid && in_ready && in_hdr.outer_tagged && !in_hdr.pushes_tags &&
		oam_tpid_ignore_mask_reg[prt][in_hdr.outer_tpid_sel]) |=>
		st_reg.pcp == $past(oam_fallback_priority_reg[prt]) &&
		st_reg.dei == $past(oam_fallback_drop_bit_reg[prt]))
		else $error("ignored tpid not seen as untagged");

	chk_known_tpid: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(in_valid && in_ready && in_hdr.outer_tagged && !in_hdr.pushes_tags &&
		!oam_tpid_ignore_mask_reg[prt][in_hdr.outer_tpid_sel]) |=>
		st_reg.pcp == $past(in_hdr.outer_pcp) && st_reg.dei == $past(in_hdr.outer_dei))
		else $error("outer pcp or dei not passed on");

	chk_pushed_tags: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(in_valid && in_ready && in_hdr.outer_tagged && in_hdr.pushes_tags) |=>
		st_reg.pcp == $past(in_hdr.outer_pcp) && st_reg.dei == $past(in_hdr.outer_dei))
		else $error("tpid mask applied to pushed tags");

	chk_req_held: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(oam_req_valid && !oam_rsp_valid) |=> oam_req_valid && $stable(oam_req))
		else $error("oam request dropped before answer");

	chk_plain_emits: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_plain_taken |=> out_valid && !oam_req_valid)
		else $error("plain frame sent to processor");

	chk_index_kept: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(oam_req_valid && oam_rsp_valid && !oam_rsp.set_service) |=>
		out_hdr.service_index == $past(st_reg.hdr.service_index))
		else $error("service index changed without request");

	chk_out_held: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(out_valid && !out_ready) |=> out_valid && $stable(out_hdr) && $stable(out_pdu))
		else $error("emitted frame changed before taken");

endmodule

// >>> testbench/rlr_oam_model.sv
// behavioural oam processor answering the rewriter's pdu requests
// assumes one request at a time; answer delay and service index rewrite set by the bench
`timescale 1ns/1ps
module rlr_oam_model (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	// request side
	input  wire logic             oam_req_valid,
	input  rlr_pkg::rlr_oam_req_s oam_req,
	// bench controls and observations
	input  wire logic [3:0]       delay,
	input  wire logic             set_service,
	output logic      [2:0]       seen_pcp,
	output logic                  seen_dei,
	// answer side
	output logic                  oam_rsp_valid,
	output rlr_pkg::rlr_oam_rsp_s oam_rsp
);
	logic [3:0] wait_cnt;

	// idle answer lines toggle so a stale value is never mistaken for an answer
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_cnt      <= 4'h0;
			oam_rsp_valid <= 1'b0;
			oam_rsp       <= '0;
			seen_pcp      <= 3'h0;
			seen_dei      <= 1'b0;
		end else begin
			oam_rsp_valid <= 1'b0;
			oam_rsp       <= ~oam_rsp;
			if (oam_req_valid && !oam_rsp_valid) begin
				if (wait_cnt == delay) begin
					wait_cnt              <= 4'h0;
					oam_rsp_valid         <= 1'b1;
					oam_rsp.pdu           <= ~oam_req.pdu;
					oam_rsp.set_service   <= set_service;
					oam_rsp.service_index <= 10'h2a5;
					seen_pcp              <= oam_req.pcp;
					seen_dei              <= oam_req.dei;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
		end
	end
endmodule

// >>> testbench/rlr_rewriter_tb_top.sv
// self-checking bench for the routed-frame and oam tag rewriter slice
// assumes rlr_oam_model stands at the oam processor side
`timescale 1ns/1ps
`include "rlr_defs.svh"
module rlr_rewriter_tb_top;
	typedef struct packed {
		logic [1:0]  kind;
		logic [1:0]  dest;
		logic        rtf;
		logic [4:0]  leg;
		logic [47:0] smac;
		logic [11:0] vid;
		logic        tag;
	} rlr_row_s;

	logic                  ref_clk, reset_n, reg_wr, reg_rd, in_valid, in_ready;
	logic                  out_valid, out_ready, oam_req_valid, oam_rsp_valid, set_service, dei;
	logic [7:0]            reg_addr;
	logic [31:0]           reg_wdata, reg_rdata, rd;
	logic [127:0]          in_pdu, out_pdu, pdu;
	logic [3:0]            delay;
	logic [2:0]            pcp;
	rlr_pkg::rlr_hdr_s     in_hdr, out_hdr, h, got;
	rlr_pkg::rlr_oam_req_s oam_req;
	rlr_pkg::rlr_oam_rsp_s oam_rsp;
	int                    bad_count, check_count;
	rlr_row_s              rows[6] = '{
		'{2'h0, 2'h1, 1'b0, 5'd5, 48'h123456000010, 12'h0a5, 1'b1},
		'{2'h1, 2'h1, 1'b0, 5'd5, 48'h123456000095, 12'h0a5, 1'b1},
		'{2'h2, 2'h2, 1'b0, 5'd31, 48'h123456fffff0, 12'hfff, 1'b0},
		'{2'h3, 2'h2, 1'b0, 5'd31, 48'h123456fffff0, 12'hfff, 1'b0},
		'{2'h0, 2'h0, 1'b0, 5'd31, 48'h0a0b0c0d0e0f, 12'h0a5, 1'b1},
		'{2'h0, 2'h1, 1'b1, 5'd31, 48'h0a0b0c0d0e0f, 12'h0a5, 1'b1}};

	rlr_rewriter dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.in_valid(in_valid), .in_ready(in_ready), .in_hdr(in_hdr), .in_pdu(in_pdu),
		.out_valid(out_valid), .out_ready(out_ready), .out_hdr(out_hdr), .out_pdu(out_pdu),
		.oam_req_valid(oam_req_valid), .oam_req(oam_req), .oam_rsp_valid(oam_rsp_valid),
		.oam_rsp(oam_rsp));
	rlr_oam_model oam_proc (.ref_clk(ref_clk), .reset_n(reset_n),
		.oam_req_valid(oam_req_valid), .oam_req(oam_req), .delay(delay),
		.set_service(set_service), .seen_pcp(pcp), .seen_dei(dei),
		.oam_rsp_valid(oam_rsp_valid), .oam_rsp(oam_rsp));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		check_count++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task rdr(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1 rd = reg_rdata;
	endtask

	task xfer(input rlr_pkg::rlr_hdr_s hi, input logic [127:0] p);
		int n;
		@(posedge ref_clk);
		in_valid <= 1'b1;
		in_hdr   <= hi;
		in_pdu   <= p;
		@(posedge ref_clk);
		in_valid <= 1'b0;
		#1 chk("in_ready busy", 0, in_ready);
		n = 0;
		while (out_valid !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk("out_valid", 1, out_valid);
		got = out_hdr;
		pdu = out_pdu;
		@(posedge ref_clk);
		out_ready <= 1'b1;
		@(posedge ref_clk);
		out_ready <= 1'b0;
	endtask

	// ----------------------------------------
	// clock, watchdog, sequence
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		test_done;
	end

	initial begin
		{reset_n, reg_wr, reg_rd, in_valid, out_ready, set_service} = '0;
		{reg_addr, reg_wdata, in_pdu, delay} = '0;
		in_hdr = '0;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		rdr(8'h25);
		chk("leg reset", 0, rd);
		wr(8'h00, 32'h00fffff0);
		wr(8'h25, 32'h000010a5);
		wr(8'h3f, 32'h00000fff);
		wr(8'h05, 32'hffffffff);
		// last port entry sits just below the status word
		wr(8'h0f, 32'h000000a5);
		rdr(8'h25);
		chk("leg rw", 32'h10a5, rd);
		rdr(8'h05);
		chk("unmapped", 0, rd);
		rdr(8'h0f);
		chk("port rw", 32'ha5, rd);
		$display("test regs done");
		foreach (rows[i]) begin
			wr(8'h01, {6'h0, rows[i].kind, 24'h123456});
			h = '0;
			h.fwd_dest_kind = rows[i].dest;
			h.analyzer_routed_forward = rows[i].rtf;
			h.egress_leg_index = rows[i].leg;
			h.mapped_vlan_index = 8'h20;
			h.vid = 12'h0a5;
			h.smac = 48'h0a0b0c0d0e0f;
			h.prior_tag_flag = 1'b1;
			xfer(h, 128'h0);
			chk("smac", rows[i].smac, got.smac);
			chk("vid", rows[i].vid, got.vid);
			chk("tag", rows[i].tag, got.prior_tag_flag);
		end
		$display("test rows done");
		// port 2: ignore tpid 1, fallback priority 5, fallback drop bit 1
		wr(8'h0a, 32'h000000d2);
		for (int k = 0; k < 4; k++) begin
			delay <= 4'(k * 5);
			set_service <= k[0] ? 1'b0 : 1'b1;
			h = '0;
			h.is_oam = 1'b1;
			h.port = 3'h2;
			h.service_index = 10'h011;
			h.outer_tagged = (k != 2);
			h.outer_tpid_sel = (k == 3) ? 2'h0 : 2'h1;
			h.pushes_tags = (k == 1);
			h.outer_pcp = 3'h3;
			xfer(h, {4{32'h1234abcd + k}});
			chk("pdu", ~{4{32'h1234abcd + k}}, pdu);
			chk("service index", k[0] ? 10'h011 : 10'h2a5, got.service_index);
			chk("pcp", k[0] ? 3'h3 : 3'h5, pcp);
			chk("dei", k[0] ? 1'b0 : 1'b1, dei);
		end
		rdr(`RLR_OFS_STATUS);
		chk("oam count", 32'h4, rd);
		$display("test oam done");
		// reset while an oam frame still waits for its answer
		delay <= 4'hf;
		@(posedge ref_clk);
		in_valid <= 1'b1;
		in_hdr   <= h;
		@(posedge ref_clk);
		in_valid <= 1'b0;
		@(posedge ref_clk);
		reset_n <= 1'b0;
		@(posedge ref_clk);
		reset_n <= 1'b1;
		#1 chk("ready after reset", 1, in_ready);
		chk("request after reset", 0, oam_req_valid);
		chk("out after reset", 0, out_valid);
		rdr(8'h00);
		chk("low after reset", 0, rd);
		rdr(`RLR_OFS_STATUS);
		chk("count after reset", 0, rd);
		$display("test reset done");
		test_done;
	end
endmodule
